// File: rtl/ctuo_pkg.sv
// package of register addresses, field layouts and codes for the test/observe unit
package ctuo_pkg;
    // ******************************************
    // register addresses (sfr and extended space)
    // ******************************************
    localparam logic [15:0] ADDR_COMMAND = 16'h00d1;
    localparam logic [15:0] ADDR_FIFO_DATA = 16'h00ea;
    localparam logic [15:0] ADDR_FIFO_LEVEL = 16'h00eb;
    localparam logic [15:0] ADDR_OBSERVE = 16'h6104;
    localparam logic [15:0] ADDR_TEST_CFG2 = 16'h6322;
    localparam logic [15:0] ADDR_SELFTEST = 16'h6326;
    localparam logic [15:0] ADDR_ANALOG_TEST = 16'h6328;

    // ******************************************
    // command codes
    // ******************************************
    localparam logic [3:0] CMD_IDLE = 4'h0;
    localparam logic [3:0] CMD_TRANSMIT = 4'h4;
    localparam logic [3:0] CMD_CHECKSUM = 4'h3;
    localparam logic [3:0] CMD_SOFT_REINIT = 4'hf;

    // ******************************************
    // fields and values
    // ******************************************
    localparam logic [7:0] SELFTEST_ARM = 8'h09;
    localparam logic [4:0] BUS_GROUP_RX = 5'h07;
    localparam logic [4:0] BUS_GROUP_CLK = 5'h0d;
    localparam int PRBS_EN_BIT = 7;
    localparam int PRBS_15_BIT = 6;
    localparam int OBSERVE_BIT = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int FIFO_DEPTH = 64;
    localparam int SIG_LEN = 64;
endpackage

// File: rtl/ctuo_prbs.sv
// pseudo-random bit stream generator, 9-bit or 15-bit polynomial
`timescale 1ns/1ps
module ctuo_prbs (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic run_i,
    input wire logic long_i,
    input wire logic step_i,
    // stream
    output logic bit_o
);
    logic [14:0] lfsr_q;
    logic [14:0] lfsr_d;
    logic fb;

    // x^9+x^5+1 or x^15+x^14+1 feedback per the itu patterns
    assign fb = long_i ? (lfsr_q[14] ^ lfsr_q[13]) : (lfsr_q[8] ^ lfsr_q[4]);
    assign lfsr_d = {lfsr_q[13:0], fb};
    assign bit_o = long_i ? lfsr_q[14] : lfsr_q[8];

    // all-ones seed keeps the register out of the lock-up state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lfsr_q <= 15'h7fff;
        end else if (!run_i) begin
            lfsr_q <= 15'h7fff;
        end else if (step_i) begin
            lfsr_q <= lfsr_d;
        end
    end
endmodule

// File: rtl/ctuo_fifo.sv
// byte fifo with single data port and fill level
`timescale 1ns/1ps
module ctuo_fifo #(
    parameter int DEPTH = 64
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic clear_i,
    input wire logic push_i,
    input wire logic [7:0] push_data_i,
    input wire logic pop_i,
    // status
    output logic [7:0] head_o,
    output logic [7:0] level_o
);
    localparam int AW = $clog2(DEPTH);
    logic [7:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic do_push;
    logic do_pop;

    // writes to a full fifo and reads from an empty one are dropped
    assign do_push = push_i && (cnt_q != (AW+1)'(DEPTH));
    assign do_pop = pop_i && (cnt_q != '0);
    assign head_o = mem_q[rd_q];
    assign level_o = 8'(cnt_q);

    // pointers and count
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (clear_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_q + AW'(do_push);
            rd_q <= rd_q + AW'(do_pop);
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // storage
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wr_q] <= push_data_i;
        end
    end
endmodule

// File: rtl/ctuo_top.sv
// test, observe and self-test logic of the contactless interface unit
// ******************************************
// ******************************************
`timescale 1ns/1ps
module ctuo_top #(
    parameter int FIFO_DEPTH = ctuo_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // firmware register access
    input wire logic reg_sfr_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // internal receiver and coder signals
    input wire logic rx_data_i,
    input wire logic rx_coll_i,
    input wire logic rx_valid_i,
    input wire logic rx_stop_i,
    input wire logic receiver_held_reset_i,
    input wire logic rf_level_i,
    input wire logic coder_env_i,
    input wire logic rate_106_i,
    input wire logic type_a_i,
    // clock observation inputs
    input wire logic osc_stable_i,
    input wire logic osc_clk_i,
    input wire logic rf2_clk_i,
    input wire logic rf_clk_i,
    input wire logic bit_tick_i,
    // pads
    output logic [5:0] port_pad_o,
    output logic [5:0] port_pad_oe_n_o,
    output logic reset_out_pad_o,
    output logic reset_out_pad_oe_n_o,
    output logic interrupt_pad_o,
    output logic interrupt_pad_oe_n_o,
    output logic aux_pin_one_o,
    output logic aux_pin_two_o,
    // transmit stream
    output logic tx_prbs_active_o,
    output logic tx_prbs_bit_o,
    output logic [3:0] command_o
);
    // ******************************************
    // reset and input synchronisers
    // ******************************************
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [11:0] sync1_q;
    logic [11:0] sync2_q;
    logic [11:0] async_in;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign async_in = {rx_data_i, rx_coll_i, rx_valid_i, rx_stop_i, receiver_held_reset_i,
                       rf_level_i, coder_env_i, osc_stable_i, osc_clk_i, rf2_clk_i,
                       rf_clk_i, bit_tick_i};

    // two-stage sync of pad-side signals
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
        end
    end

    wire s_rx_data = sync2_q[11];
    wire s_rx_coll = sync2_q[10];
    wire s_rx_valid = sync2_q[9];
    wire s_rx_stop = sync2_q[8];
    wire s_rcv_rst = sync2_q[7];
    wire s_rf_lvl = sync2_q[6];
    wire s_env = sync2_q[5];
    wire s_osc_ok = sync2_q[4];
    wire s_osc = sync2_q[3];
    wire s_rf2 = sync2_q[2];
    wire s_rf = sync2_q[1];
    wire s_tick = sync2_q[0];

    // ******************************************
    // register decode
    // ******************************************
    typedef enum logic [1:0] {CTUO_IDLE, CTUO_SELFTEST, CTUO_PRBS} ctuo_state_e;

    logic [3:0] command_q;
    logic [7:0] selftest_q;
    logic [7:0] test_cfg2_q;
    logic [7:0] analog_test_q;
    logic observe_q;
    ctuo_state_e state_q;
    logic [6:0] sig_idx_q;
    logic soft_reinit;
    logic [7:0] fifo_head;
    logic [7:0] fifo_level;

    // sfr space reaches the low page, extended space the full address
    wire [15:0] eff_addr = reg_sfr_i ? {8'h00, reg_addr_i[7:0]} : reg_addr_i;
    wire hit_cmd = eff_addr == ctuo_pkg::ADDR_COMMAND;
    wire hit_fdata = eff_addr == ctuo_pkg::ADDR_FIFO_DATA;
    wire hit_flevel = eff_addr == ctuo_pkg::ADDR_FIFO_LEVEL;
    wire hit_obs = eff_addr == ctuo_pkg::ADDR_OBSERVE;
    wire hit_cfg2 = eff_addr == ctuo_pkg::ADDR_TEST_CFG2;
    wire hit_self = eff_addr == ctuo_pkg::ADDR_SELFTEST;
    wire hit_ana = eff_addr == ctuo_pkg::ADDR_ANALOG_TEST;
    wire wr_cmd = reg_wr_i && hit_cmd;
    wire st_armed = selftest_q == ctuo_pkg::SELFTEST_ARM;
    wire st_start = wr_cmd && reg_wdata_i[3:0] == ctuo_pkg::CMD_CHECKSUM && st_armed;
    wire prbs_en = test_cfg2_q[ctuo_pkg::PRBS_EN_BIT];
    wire [4:0] bus_group_select = test_cfg2_q[4:0];
    wire fifo_push_fw = reg_wr_i && hit_fdata && state_q == CTUO_IDLE;
    wire fifo_pop_fw = reg_rd_i && hit_fdata;
    wire sig_push = state_q == CTUO_SELFTEST;

    assign soft_reinit = wr_cmd && reg_wdata_i[3:0] == ctuo_pkg::CMD_SOFT_REINIT;

    // ******************************************
    // signature table
    // ******************************************
    function automatic logic [7:0] sig_byte(input logic [5:0] i);
        logic [7:0] t [64];
        t = '{8'h00, 8'haa, 8'he3, 8'h29, 8'h0c, 8'h10, 8'h29, 8'h6b,
              8'h76, 8'h8d, 8'haf, 8'h4b, 8'ha2, 8'hda, 8'h76, 8'h99,
              8'hc7, 8'h5e, 8'h24, 8'h69, 8'hd2, 8'hba, 8'hfa, 8'hbc,
              8'h3e, 8'hda, 8'h96, 8'hb5, 8'hf5, 8'h94, 8'hb0, 8'h3a,
              8'h4e, 8'hc3, 8'h9d, 8'h94, 8'h76, 8'h4c, 8'hea, 8'h5e,
              8'h38, 8'h10, 8'h8f, 8'h2d, 8'h21, 8'h4b, 8'h52, 8'hbf,
              8'hfb, 8'hf4, 8'h19, 8'h94, 8'h82, 8'h5a, 8'h72, 8'h9d,
              8'hba, 8'h0d, 8'h1f, 8'h17, 8'h56, 8'h22, 8'hb9, 8'h08};
        return t[i];
    endfunction

    // ******************************************
    // fifo
    // ******************************************
    // self-test clears the fifo and refills it with the signature
    ctuo_fifo #(
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .clear_i(soft_reinit || st_start),
        .push_i(fifo_push_fw || sig_push),
        .push_data_i(sig_push ? sig_byte(sig_idx_q[5:0]) : reg_wdata_i),
        .pop_i(fifo_pop_fw),
        .head_o(fifo_head),
        .level_o(fifo_level)
    );

    // ******************************************
    // command state machine
    // ******************************************
    // self-test streams one signature byte per cycle, then drops to idle
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CTUO_IDLE;
            command_q <= ctuo_pkg::CMD_IDLE;
            sig_idx_q <= '0;
        end else if (soft_reinit) begin
            state_q <= CTUO_IDLE;
            command_q <= ctuo_pkg::CMD_IDLE;
            sig_idx_q <= '0;
        end else if (wr_cmd) begin
            command_q <= reg_wdata_i[3:0];
            sig_idx_q <= '0;
            case (reg_wdata_i[3:0])
                ctuo_pkg::CMD_CHECKSUM: begin
                    state_q <= st_armed ? CTUO_SELFTEST : CTUO_IDLE;
                end
                ctuo_pkg::CMD_TRANSMIT: begin
                    state_q <= prbs_en ? CTUO_PRBS : CTUO_IDLE;
                end
                default: begin
                    state_q <= CTUO_IDLE;
                end
            endcase
        end else begin
            case (state_q)
                CTUO_SELFTEST: begin
                    sig_idx_q <= sig_idx_q + 7'h01;
                    if (sig_idx_q == 7'(ctuo_pkg::SIG_LEN - 1)) begin
                        state_q <= CTUO_IDLE;
                        command_q <= ctuo_pkg::CMD_IDLE;
                    end
                end
                CTUO_PRBS: begin
                    if (!prbs_en) begin
                        state_q <= CTUO_IDLE;
                        command_q <= ctuo_pkg::CMD_IDLE;
                    end
                end
                default: begin
                    state_q <= CTUO_IDLE;
                end
            endcase
        end
    end

    // ******************************************
    // test configuration registers
    // ******************************************
    // soft reinit brings every register back to its reset value
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            selftest_q <= ctuo_pkg::RESET_BYTE;
            test_cfg2_q <= ctuo_pkg::RESET_BYTE;
            analog_test_q <= ctuo_pkg::RESET_BYTE;
            observe_q <= 1'b0;
        end else if (soft_reinit) begin
            selftest_q <= ctuo_pkg::RESET_BYTE;
            test_cfg2_q <= ctuo_pkg::RESET_BYTE;
            analog_test_q <= ctuo_pkg::RESET_BYTE;
            observe_q <= 1'b0;
        end else if (reg_wr_i) begin
            if (hit_self) begin
                selftest_q <= reg_wdata_i;
            end
            if (hit_cfg2) begin
                test_cfg2_q <= reg_wdata_i;
            end
            if (hit_ana) begin
                analog_test_q <= reg_wdata_i;
            end
            if (hit_obs) begin
                observe_q <= reg_wdata_i[ctuo_pkg::OBSERVE_BIT];
            end
        end
    end

    // ******************************************
    // read mux
    // ******************************************
    // unmapped addresses read zero
    wire [7:0] rd_mux = hit_cmd ? {4'h0, command_q} :
                        hit_fdata ? fifo_head :
                        hit_flevel ? fifo_level :
                        hit_obs ? {7'h00, observe_q} :
                        hit_cfg2 ? test_cfg2_q :
                        hit_self ? selftest_q :
                        hit_ana ? analog_test_q : 8'h00;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    // ******************************************
    // test bus
    // ******************************************
    logic [2:0] osc_div_q;
    logic [2:0] rf2_div_q;
    logic [1:0] rf_div_q;
    logic osc_d_q;
    logic rf2_d_q;
    logic rf_d_q;

    // dividers count rising edges of the sampled clocks; slow enough for 250 MHz
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            osc_div_q <= '0;
            rf2_div_q <= '0;
            rf_div_q <= '0;
            osc_d_q <= 1'b0;
            rf2_d_q <= 1'b0;
            rf_d_q <= 1'b0;
        end else begin
            osc_d_q <= s_osc;
            rf2_d_q <= s_rf2;
            rf_d_q <= s_rf;
            osc_div_q <= osc_div_q + 3'(s_osc && !osc_d_q);
            rf2_div_q <= rf2_div_q + 3'(s_rf2 && !rf2_d_q);
            rf_div_q <= rf_div_q + 2'(s_rf && !rf_d_q);
        end
    end

    // collision and stop lines forced low outside their valid modes
    wire [6:0] grp_rx = {s_rx_data, s_rx_coll && rate_106_i, s_rx_valid,
                         s_rx_stop && type_a_i, s_rcv_rst, s_rf_lvl, s_env};
    wire [6:0] grp_clk = {s_osc_ok, osc_div_q[2], rf2_div_q[2], rf_div_q[1],
                          s_osc, s_rf2, s_rf};
    wire [6:0] test_bus = (bus_group_select == ctuo_pkg::BUS_GROUP_RX) ? grp_rx :
                          (bus_group_select == ctuo_pkg::BUS_GROUP_CLK) ? grp_clk :
                          7'h00;

    // ******************************************
    // pad and aux outputs
    // ******************************************
    logic [6:0] bus_q;
    logic irq_q;
    logic aux_one_q;
    logic aux_two_q;

    // aux select picks one of the 14 group lines; index 0 and above 14 give low
    function automatic logic aux_pick(input logic [3:0] sel, input logic [13:0] sigs);
        return (sel == 4'h0 || sel > 4'he) ? 1'b0 : sigs[sel - 4'h1];
    endfunction

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_q <= '0;
            irq_q <= 1'b0;
            aux_one_q <= 1'b0;
            aux_two_q <= 1'b0;
        end else begin
            bus_q <= test_bus;
            irq_q <= s_rf;
            aux_one_q <= aux_pick(analog_test_q[7:4], {grp_clk, grp_rx});
            aux_two_q <= aux_pick(analog_test_q[3:0], {grp_clk, grp_rx});
        end
    end

    assign port_pad_o = bus_q[5:0];
    assign reset_out_pad_o = bus_q[6];
    assign interrupt_pad_o = irq_q;
    assign port_pad_oe_n_o = {6{!observe_q}};
    assign reset_out_pad_oe_n_o = !observe_q;
    assign interrupt_pad_oe_n_o = !observe_q;
    assign aux_pin_one_o = aux_one_q;
    assign aux_pin_two_o = aux_two_q;

    // ******************************************
    // prbs transmit
    // ******************************************
    wire prbs_run = state_q == CTUO_PRBS;

    ctuo_prbs u_prbs (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .run_i(prbs_run),
        .long_i(test_cfg2_q[ctuo_pkg::PRBS_15_BIT]),
        .step_i(s_tick),
        .bit_o(tx_prbs_bit_o)
    );

    assign tx_prbs_active_o = prbs_run;
    assign command_o = command_q;
endmodule

// File: dv/ctuo_top_asserts.sv
// concurrent checks on the ports of the test and observe unit
`timescale 1ns/1ps
module ctuo_top_asserts #(
    parameter int FIFO_DEPTH = ctuo_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // register access
    input wire logic reg_sfr_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // pads and command state
    input wire logic [5:0] port_pad_oe_n_o,
    input wire logic reset_out_pad_oe_n_o,
    input wire logic interrupt_pad_oe_n_o,
    input wire logic tx_prbs_active_o,
    input wire logic [3:0] command_o
);
    // ****
    // checks
    // ****
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    // command register write, decoded once for several checks
    wire cmd_wr = reg_wr_i && reg_sfr_i && reg_addr_i[7:0] == ctuo_pkg::ADDR_COMMAND[7:0];
    group_same_a: assert property (port_pad_oe_n_o == {6{reset_out_pad_oe_n_o}})
        else $error("port pads and reset pad differ in drive");
    irq_same_a: assert property (interrupt_pad_oe_n_o == reset_out_pad_oe_n_o)
        else $error("interrupt pad drive differs");
    obs_read_a: assert property (reg_rd_i && !reg_sfr_i &&
        reg_addr_i == ctuo_pkg::ADDR_OBSERVE |=> reg_rdata_o[7:1] == 7'h00)
        else $error("observe reserved bits not zero");
    soft_idle_a: assert property (cmd_wr &&
        reg_wdata_i[3:0] == ctuo_pkg::CMD_SOFT_REINIT |-> ##[1:2] command_o == 4'h0)
        else $error("soft reset did not end idle");
    idle_cmd_a: assert property (cmd_wr && reg_wdata_i[3:0] == 4'h0
        |=> command_o == ctuo_pkg::CMD_IDLE) else $error("idle command not taken");
    prbs_start_a: assert property ($rose(tx_prbs_active_o)
        |-> $past(cmd_wr) && command_o == ctuo_pkg::CMD_TRANSMIT)
        else $error("stream started without transmit command");
    // a write one cycle back (enable cleared) stops the stream one cycle late
    prbs_hold_a: assert property (tx_prbs_active_o && !reg_wr_i && !$past(reg_wr_i)
        |=> tx_prbs_active_o)
        else $error("stream stopped without a write");
    selftest_end_a: assert property ($rose(command_o == ctuo_pkg::CMD_CHECKSUM)
        |-> ##[60:70] command_o == ctuo_pkg::CMD_IDLE) else $error("self-test length wrong");
    // pad drive only moves after a register write (observe bit or soft reset)
    oe_cause_a: assert property (!$stable(reset_out_pad_oe_n_o)
        |-> $past(reg_wr_i) || $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
        else $error("pad drive changed without write");
    cover property ($fell(reset_out_pad_oe_n_o));
    cover property ($rose(command_o == ctuo_pkg::CMD_CHECKSUM));
    cover property ($rose(tx_prbs_active_o));
endmodule

// File: dv/ctuo_observer.sv
// pad-side test equipment model watching the observe outputs
`timescale 1ns/1ps
module ctuo_observer (
    // sampling clock of the equipment
    input wire logic clk_i,
    // observed pads
    input wire logic [5:0] port_pad_i,
    input wire logic [5:0] port_oe_n_i,
    input wire logic rst_pad_i,
    input wire logic rst_oe_n_i,
    input wire logic irq_pad_i,
    input wire logic irq_oe_n_i,
    // what the equipment sees
    output logic [6:0] bus_o,
    output logic [15:0] irq_edges_o
);
    // ****
    // pad levels
    // ****
    logic [6:0] last_q = 7'h00;
    wire [6:0] pin = {rst_pad_i, port_pad_i};
    wire [6:0] drv = ~{rst_oe_n_i, port_oe_n_i};
    // released pads have no pull, so they show a level that keeps moving
    assign bus_o = (pin & drv) | (~last_q & ~drv);
    always @(posedge clk_i) last_q <= bus_o;
    // clock on the interrupt pad only counts while the pad is driven
    logic [15:0] edges_q = 16'h0000;
    assign irq_edges_o = edges_q;
    always @(posedge irq_pad_i) if (!irq_oe_n_i) edges_q <= edges_q + 16'h0001;
endmodule

// File: dv/contactless_unit_test_observe_test.sv
// self-checking bench of the test and observe unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("CHECK FAILED %s exp %h got %h", n, (e), (g)); \
    end \
end
module contactless_unit_test_observe_test;
    // ****
    // signals
    // ****
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic reg_sfr_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [6:0] rx = 7'h00; // receiver group d6..d0
    logic [3:0] ck = 4'h0; // stable, oscillator, doubled rf, rf
    logic rate_106_i = 1'b0;
    logic type_a_i = 1'b0;
    logic bit_tick_i = 1'b0;
    logic [7:0] reg_rdata_o, d;
    logic [5:0] port_pad_o, port_pad_oe_n_o;
    logic reset_out_pad_o, reset_out_pad_oe_n_o, interrupt_pad_o, interrupt_pad_oe_n_o;
    logic aux_pin_one_o, aux_pin_two_o, tx_prbs_active_o, tx_prbs_bit_o;
    logic [3:0] command_o;
    logic [6:0] obs_bus;
    logic [15:0] irq_edges, n0;
    logic [39:0] sq;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int k, m, e1, e2, ln, t1, t2;
    typedef struct packed {
        logic [7:0] sel2;
        logic [7:0] ana;
        logic [6:0] rx;
        logic [3:0] ck;
        logic [1:0] mode;
        logic [6:0] bus;
        logic [6:0] mask;
        logic [1:0] aux;
    } ctuo_row_s;
    // group, aux selects, inputs, {rate, type}, expected bus, bits judged, aux pins
    ctuo_row_s rows [5] = '{
        '{8'h07, 8'h71, 7'h7f, 4'h0, 2'h3, 7'h7f, 7'h7f, 2'h3},
        '{8'h07, 8'h52, 7'h3d, 4'h0, 2'h0, 7'h15, 7'h7f, 2'h2},
        '{8'h07, 8'h00, 7'h3d, 4'h0, 2'h3, 7'h3d, 7'h7f, 2'h0},
        '{8'h0d, 8'h9f, 7'h00, 4'hb, 2'h0, 7'h43, 7'h47, 2'h2},
        '{8'h05, 8'he7, 7'h40, 4'h8, 2'h0, 7'h00, 7'h7f, 2'h3}};
    ctuo_top u_dut (
        .mclk_i, .arst_n_i, .reg_sfr_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
        .reg_rdata_o, .rx_data_i(rx[6]), .rx_coll_i(rx[5]), .rx_valid_i(rx[4]),
        .rx_stop_i(rx[3]), .receiver_held_reset_i(rx[2]), .rf_level_i(rx[1]),
        .coder_env_i(rx[0]), .rate_106_i, .type_a_i, .osc_stable_i(ck[3]),
        .osc_clk_i(ck[2]), .rf2_clk_i(ck[1]), .rf_clk_i(ck[0]), .bit_tick_i, .port_pad_o,
        .port_pad_oe_n_o, .reset_out_pad_o, .reset_out_pad_oe_n_o, .interrupt_pad_o,
        .interrupt_pad_oe_n_o, .aux_pin_one_o, .aux_pin_two_o, .tx_prbs_active_o,
        .tx_prbs_bit_o, .command_o);
    ctuo_observer u_obs (
        .clk_i(mclk_i), .port_pad_i(port_pad_o), .port_oe_n_i(port_pad_oe_n_o),
        .rst_pad_i(reset_out_pad_o), .rst_oe_n_i(reset_out_pad_oe_n_o),
        .irq_pad_i(interrupt_pad_o), .irq_oe_n_i(interrupt_pad_oe_n_o),
        .bus_o(obs_bus), .irq_edges_o(irq_edges));
    // ****
    // tasks
    // ****
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // one idle edge before each access keeps strobes from toggling twice at once
    task automatic wr(input logic s, input logic [15:0] a, input logic [7:0] v);
        step(1);
        reg_sfr_i = s;
        reg_addr_i = a;
        reg_wdata_i = v;
        reg_wr_i = 1'b1;
        step(1);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic s, input logic [15:0] a, output logic [7:0] v);
        step(1);
        reg_sfr_i = s;
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        step(1);
        reg_rd_i = 1'b0;
        v = reg_rdata_o;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    // hang guard, far above the roughly 400 cycles the run needs
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end
    // ****
    // scenarios
    // ****
    initial begin
        step(10);
        arst_n_i = 1'b1;
        step(3);
        `CHK("oe after reset", 6'h3f, port_pad_oe_n_o)
        rd(1'b0, ctuo_pkg::ADDR_OBSERVE, d);
        `CHK("observe reset", 8'h00, d)
        wr(1'b0, ctuo_pkg::ADDR_OBSERVE, 8'hff);
        rd(1'b0, ctuo_pkg::ADDR_OBSERVE, d);
        `CHK("observe bits", 8'h01, d)
        step(4);
        `CHK("oe on", 6'h00, port_pad_oe_n_o)
        foreach (rows[i]) begin
            wr(1'b0, ctuo_pkg::ADDR_TEST_CFG2, rows[i].sel2);
            wr(1'b0, ctuo_pkg::ADDR_ANALOG_TEST, rows[i].ana);
            rx = rows[i].rx;
            ck = rows[i].ck;
            {rate_106_i, type_a_i} = rows[i].mode;
            step(8);
            `CHK("test bus", rows[i].bus, obs_bus & rows[i].mask)
            `CHK("aux pins", rows[i].aux, {aux_pin_one_o, aux_pin_two_o})
        end
        n0 = irq_edges;
        repeat (8) begin
            ck[0] = 1'b1;
            step(4);
            ck[0] = 1'b0;
            step(4);
        end
        step(8);
        `CHK("irq clock edges", 16'd8, irq_edges - n0)
        wr(1'b1, ctuo_pkg::ADDR_COMMAND, 8'h0f);
        step(2);
        `CHK("soft reset idle", ctuo_pkg::CMD_IDLE, command_o)
        rd(1'b0, ctuo_pkg::ADDR_OBSERVE, d);
        `CHK("observe cleared", 8'h00, d)
        repeat (25) wr(1'b1, ctuo_pkg::ADDR_FIFO_DATA, 8'h00);
        rd(1'b1, ctuo_pkg::ADDR_FIFO_LEVEL, d);
        `CHK("level 25", 8'd25, d)
        wr(1'b0, ctuo_pkg::ADDR_SELFTEST, ctuo_pkg::SELFTEST_ARM);
        wr(1'b1, ctuo_pkg::ADDR_FIFO_DATA, 8'h00);
        wr(1'b1, ctuo_pkg::ADDR_COMMAND, {4'h0, ctuo_pkg::CMD_CHECKSUM});
        `CHK("self-test runs", ctuo_pkg::CMD_CHECKSUM, command_o)
        for (k = 0; k < 200 && command_o !== ctuo_pkg::CMD_IDLE; k++) step(1);
        rd(1'b1, ctuo_pkg::ADDR_FIFO_LEVEL, d);
        `CHK("signature level", 8'd64, d)
        rd(1'b1, ctuo_pkg::ADDR_FIFO_DATA, d);
        `CHK("signature 0", 8'h00, d)
        rd(1'b1, ctuo_pkg::ADDR_FIFO_DATA, d);
        `CHK("signature 1", 8'haa, d)
        rd(1'b1, ctuo_pkg::ADDR_FIFO_LEVEL, d);
        `CHK("level after pops", 8'd62, d)
        for (m = 0; m < 2; m++) begin
            wr(1'b0, ctuo_pkg::ADDR_TEST_CFG2, m ? 8'hc0 : 8'h80);
            wr(1'b1, ctuo_pkg::ADDR_COMMAND, {4'h0, ctuo_pkg::CMD_TRANSMIT});
            step(1);
            `CHK("stream active", 1'b1, tx_prbs_active_o)
            bit_tick_i = 1'b1;
            step(6);
            for (k = 0; k < 40; k++) begin
                sq[k] = tx_prbs_bit_o;
                step(1);
            end
            bit_tick_i = 1'b0;
            ln = m ? 15 : 9;
            t1 = m ? 14 : 5;
            t2 = m ? 1 : 4;
            e1 = 0;
            e2 = 0;
            // either bit order of the polynomial is accepted
            for (k = ln; k < 40; k++) begin
                e1 += (sq[k] !== (sq[k-ln] ^ sq[k-t1]));
                e2 += (sq[k] !== (sq[k-ln] ^ sq[k-t2]));
            end
            `CHK("stream recurrence", 1'b1, (e1 == 0 || e2 == 0) && sq != 40'h0)
            wr(1'b0, ctuo_pkg::ADDR_TEST_CFG2, 8'h00);
            step(2);
            `CHK("stream stopped", 1'b0, tx_prbs_active_o)
        end
        wr(1'b1, ctuo_pkg::ADDR_COMMAND, {4'h0, ctuo_pkg::CMD_TRANSMIT});
        wr(1'b1, ctuo_pkg::ADDR_COMMAND, {4'h0, ctuo_pkg::CMD_IDLE});
        `CHK("idle command", ctuo_pkg::CMD_IDLE, command_o)
        summarize();
    end
endmodule
bind ctuo_top ctuo_top_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .mclk_i, .arst_n_i, .reg_sfr_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .port_pad_oe_n_o, .reset_out_pad_oe_n_o, .interrupt_pad_oe_n_o,
    .tx_prbs_active_o, .command_o);
